// ==== fbws_consts.vh ====
// Constants for the full-bridge waveform steering block
`ifndef FBWS_CONSTS_VH
`define FBWS_CONSTS_VH
`define FBWS_MODE_W        3
`define FBWS_MODE_FWD      3'h2
`define FBWS_MODE_REV      3'h3
`define FBWS_DB_W          6
`define FBWS_POL_A         0
`define FBWS_POL_B         1
`define FBWS_POL_C         2
`define FBWS_POL_D         3
`define FBWS_POL_RST       4'h0
`define FBWS_DIR_FWD       1'b0
`define FBWS_DIR_REV       1'b1
`endif

// ==== fbws_deadband.v ====
// Direction-switch dead-band counter
`timescale 1ns/100ps
`include "fbws_consts.vh"
module fbws_deadband #(
    parameter DB_W = `FBWS_DB_W
) (
    mclk,
    reset,
    start,
    count,
    busy
);
    input  wire            mclk;
    input  wire            reset;
    input  wire            start;
    input  wire [DB_W-1:0] count;
    output wire            busy;

    reg [DB_W-1:0] cnt_r;
    reg            run_r;

    // Busy covers the start cycle too so the outgoing direction's modulated output never glitches on
    assign busy = run_r | start;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= {DB_W{1'b0}};
            run_r <= 1'b0;
        end else if (start) begin
            cnt_r <= count;
            run_r <= (count != {DB_W{1'b0}});
        end else if (run_r) begin
            if (cnt_r <= {{(DB_W-1){1'b0}}, 1'b1}) begin
                run_r <= 1'b0;
                cnt_r <= {DB_W{1'b0}};
            end else begin
                cnt_r <= cnt_r - {{(DB_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ==== fbws_steer.v ====
// Full-bridge output steering with direction change and dead band
`timescale 1ns/100ps
`include "fbws_consts.vh"
module fbws_steer #(
    parameter DB_W = `FBWS_DB_W
) (
    mclk,
    reset,
    mode,
    polarity,
    db_count,
    mod_in,
    bridge_out_a,
    bridge_out_b,
    bridge_out_c,
    bridge_out_d,
    dir_busy
);
    input  wire                   mclk;
    input  wire                   reset;
    input  wire [`FBWS_MODE_W-1:0] mode;
    input  wire [3:0]             polarity;
    input  wire [DB_W-1:0]        db_count;
    input  wire                   mod_in;
    output reg                    bridge_out_a;
    output reg                    bridge_out_b;
    output reg                    bridge_out_c;
    output reg                    bridge_out_d;
    output wire                   dir_busy;

    // Modulated input arrives from outside and is synchronised first
    reg  mod_s1_r;
    reg  mod_s2_r;
    reg  mod_prev_r;
    reg  dir_r;
    reg  bridge_r;
    wire rise;
    wire mode_bridge;
    wire mode_dir;
    wire switch;
    wire db_busy;
    wire mod_ok;
    reg  a_nxt;
    reg  b_nxt;
    reg  c_nxt;
    reg  d_nxt;

    assign rise        = mod_s2_r & ~mod_prev_r;
    // Only the mode field steers direction; no separate reverse strobe exists
    assign mode_bridge = (mode == `FBWS_MODE_FWD) | (mode == `FBWS_MODE_REV);
    assign mode_dir    = (mode == `FBWS_MODE_REV) ? `FBWS_DIR_REV : `FBWS_DIR_FWD;
    // Within bridge operation, direction commits only on an input rising edge
    assign switch      = rise & mode_bridge & bridge_r & (mode_dir != dir_r);
    assign mod_ok      = ~db_busy;
    assign dir_busy    = db_busy;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            mod_s1_r   <= 1'b0;
            mod_s2_r   <= 1'b0;
            mod_prev_r <= 1'b0;
            dir_r      <= `FBWS_DIR_FWD;
            bridge_r   <= 1'b0;
        end else begin
            mod_s1_r   <= mod_in;
            mod_s2_r   <= mod_s1_r;
            mod_prev_r <= mod_s2_r;
            if (!mode_bridge) begin
                bridge_r <= 1'b0;
            end else if (!bridge_r) begin
                // Entering bridge operation takes the requested direction directly
                bridge_r <= 1'b1;
                dir_r    <= mode_dir;
            end else if (switch) begin
                dir_r <= mode_dir;
            end
        end
    end

    fbws_deadband #(
        .DB_W(DB_W)
    ) u_db (
        .mclk  (mclk),
        .reset (reset),
        .start (switch),
        .count (db_count),
        .busy  (db_busy)
    );

    // Active-high levels before polarity; all stay inactive while bridge_r is clear
    always @* begin
        a_nxt = 1'b0;
        b_nxt = 1'b0;
        c_nxt = 1'b0;
        d_nxt = 1'b0;
        if (bridge_r) begin
            if (dir_r == `FBWS_DIR_FWD) begin
                a_nxt = 1'b1;
                d_nxt = mod_s2_r & mod_ok;
            end else begin
                c_nxt = 1'b1;
                b_nxt = mod_s2_r & mod_ok;
            end
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            bridge_out_a <= 1'b0;
            bridge_out_b <= 1'b0;
            bridge_out_c <= 1'b0;
            bridge_out_d <= 1'b0;
        end else begin
            bridge_out_a <= a_nxt ^ polarity[`FBWS_POL_A];
            bridge_out_b <= b_nxt ^ polarity[`FBWS_POL_B];
            bridge_out_c <= c_nxt ^ polarity[`FBWS_POL_C];
            bridge_out_d <= d_nxt ^ polarity[`FBWS_POL_D];
        end
    end
endmodule

// ==== fbws_steer_checker.sv ====
// Assertion checker for bridge steering
`timescale 1ns/100ps
module fbws_steer_checker #(parameter DB_W = 6) (
    input wire logic            mclk,
    input wire logic            reset,
    input wire logic            mod_in,
    input wire logic            dir_busy,
    input wire logic            bridge_out_a,
    input wire logic            bridge_out_b,
    input wire logic            bridge_out_c,
    input wire logic            bridge_out_d,
    input wire logic [2:0]      mode,
    input wire logic [3:0]      polarity,
    input wire logic [DB_W-1:0] db_count
);
    logic [3:0] pol_r;
    // Lags polarity like the output flops, so a polarity write is not seen as a glitch
    always @(posedge mclk or posedge reset) pol_r <= reset ? 4'h0 : polarity;
    wire [3:0] o = {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} ^ pol_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    ac_excl_a: assert property (!(o[0] && o[2])) else $error("a c both on");
    bd_excl_a: assert property (!(o[1] && o[3])) else $error("b d both on");
    fwd_side_a: assert property (o[0] |-> !o[1] && !o[2]) else $error("fwd side");
    rev_side_a: assert property (o[2] |-> !o[0] && !o[3]) else $error("rev side");
    db_hold_a: assert property ($past(dir_busy) |-> !o[1] && !o[3]) else $error("dead band");
    // The input edge is first sampled four edges before c shows active; later samples may be a short pulse's tail
    swap_cause_a: assert property ($rose(o[2]) && $past(o[0]) |-> $past(mod_in, 4)) else $error("early");
    idle_level_a: assert property ((mode == 3'h0)[*3] |=> o == 4'h0) else $error("idle");
endmodule
bind fbws_steer fbws_steer_checker #(.DB_W(DB_W)) u_chk (.*);

// ==== fbws_gate_model.sv ====
// Gate driver stand-in
`timescale 1ns/100ps
module fbws_gate_model (
    input wire logic       mclk,
    input wire logic [3:0] gate,
    input wire logic [3:0] polarity,
    output logic           fault
);
    logic [3:0] pol_q = 4'h0;
    wire  [3:0] on = gate ^ pol_q;
    initial fault = 1'b0;
    // Both switches of one leg on would short the supply
    always @(posedge mclk) begin
        pol_q <= polarity;
        if ((on[0] && on[1]) || (on[2] && on[3])) fault <= 1'b1;
    end
endmodule

// ==== fbws_steer_tb_top.sv ====
// Directed bench for bridge steering
`timescale 1ns/100ps
`include "fbws_consts.vh"
module fbws_steer_tb_top;
    logic       mclk = 0, reset = 1, mod_in = 0;
    logic [2:0] mode = 3'h0;
    logic [3:0] polarity = 4'h0;
    logic [5:0] db_cnt = 6'h4;
    wire        a, b, c, d, busy, fault;
    wire  [3:0] o = {d, c, b, a};
    int         n_errors = 0, cmp_count = 0;
    always #25 mclk = ~mclk;
    fbws_steer u_dut (.mclk(mclk), .reset(reset), .mode(mode), .polarity(polarity), .db_count(db_cnt),
        .mod_in(mod_in), .bridge_out_a(a), .bridge_out_b(b), .bridge_out_c(c), .bridge_out_d(d), .dir_busy(busy));
    fbws_gate_model u_gate (.mclk(mclk), .gate(o), .polarity(polarity), .fault(fault));
    task cyc(input int n); repeat (n) @(posedge mclk); #5; endtask
    task chk(input string name, input logic [3:0] s, input logic [3:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", name, e, s);
        end
    endtask
    task t_fwd;
        mode = `FBWS_MODE_FWD;
        cyc(8); chk("outputs", o, 4'h1);
        mod_in = 1; cyc(5); chk("outputs", o, 4'h9);
        $display("test fwd done");
    endtask
    // Steps single edges across the switch and at the dead band's end, with a three-edge jump between, so the dead band length is pinned
    task t_dir;
        mode = `FBWS_MODE_REV;
        cyc(4); chk("outputs", o, 4'h9);
        mod_in = 0; cyc(5); chk("outputs", o, 4'h1);
        mod_in = 1; cyc(2); chk("outputs", o, 4'h1);
        chk("busy", {3'h0, busy}, 4'h1);
        cyc(1); chk("outputs", o, 4'h1);
        cyc(1); chk("outputs", o, 4'h4);
        cyc(3); chk("outputs", o, 4'h4);
        chk("busy", {3'h0, busy}, 4'h0);
        cyc(1); chk("outputs", o, 4'h6);
        $display("test dir done");
    endtask
    // Switch back to forward with no dead band
    task t_back;
        db_cnt = 6'h0; mode = `FBWS_MODE_FWD; mod_in = 0;
        cyc(4); chk("outputs", o, 4'h4);
        mod_in = 1; cyc(3); chk("outputs", o, 4'h4);
        chk("busy", {3'h0, busy}, 4'h0);
        cyc(1); chk("outputs", o, 4'h9);
        $display("test back done");
    endtask
    task t_pol;
        mode = 3'h0; polarity = 4'hf; cyc(5); chk("outputs", o, 4'hf);
        mode = `FBWS_MODE_REV; cyc(12); chk("outputs", o, 4'h9);
        $display("test pol done");
    endtask
    task end_sim;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        #5 reset = 0;
        t_fwd; t_dir; t_back; t_pol;
        chk("fault", {3'h0, fault}, 4'h0);
        end_sim;
    end
    initial begin #20000; n_errors++; end_sim; end
endmodule
